// File: verilog/serial_ctrl_pkg.sv
//Contract
//R1: completion output is driven only when its enable and receive dma mode are both set.
//R2: sync-pin select 0 makes the modem pin an input, 1 outputs sync-detected.
//R3: in character-oriented mode with strip set, received sync characters are dropped.
//R4: bit-oriented abort enable: overrun or crc error discards frame, hunts, sets end-of-frame.
//R5: receiver reset clears receive section, fifo, status; set by reset, cleared by software.
//R6: receive fifo holds eight bytes, or four words in word mode.
//R7: reads of offset 02 pop bytes or words by the word/byte select.
//R8: data-available reads 1 while the fifo holds a byte or word.
//R9: receive status condition with its enable set asserts the interrupt request.
//R10: acknowledge of a receive interrupt drives the vector register, offset 04, reset 0f.
//R11: receive interrupt enable register at 05 resets to 00, bits 5 and 0 unused.
//R12: transmit status bits clear by writing 1, by transmitter reset, or reset.
//R13: transmit status condition with its enable set asserts the interrupt request.
//R14: transmit-available reads 0 only when transmit fifo full, independent of serial clock.
//R15: bit-oriented frame-complete sets on falling serial edge ending closing flag or abort.
//R16: after abort command frame-complete waits for flush plus flag or eight mark bits.
//R17: bisync sets frame-complete after trailing pad; char mode after last flagged byte.
//R18: host waits one serial clock after frame-complete before clearing it.
//R19: bit-oriented underrun records underrun and sends abort then idle.
//R20: bisync or char-mode underrun sends sync fill until new data arrives.
//R21: underrun bit sets on rising serial edge at eighth bit before the fill.
//R22: host waits one serial clock after underrun before clearing it.
//R23: data-available clears only when the last byte or word is read.
//R24: receive control at 01 resets to 01; bit 6 selects receive dma mode.
//R25: receive and transmit requests share one active-low output, each with its vector.
package serial_ctrl_pkg;
   // register offsets on the host port
   localparam logic [4:0] OFF_RX_STATUS = 5'h00;
   localparam logic [4:0] OFF_RX_CONTROL = 5'h01;
   localparam logic [4:0] OFF_RX_DATA = 5'h02;
   localparam logic [4:0] OFF_RX_VECTOR = 5'h04;
   localparam logic [4:0] OFF_RX_IRQ_EN = 5'h05;
   localparam logic [4:0] OFF_TX_STATUS = 5'h08;
   // receive control fields
   localparam int RC_DMA = 6;
   localparam int RC_DONE_EN = 5;
   localparam int RC_SYNC_PIN = 4;
   localparam int RC_STRIP = 3;
   localparam int RC_ABORT_EN = 1;
   localparam int RC_RESET = 0;
   localparam logic [7:0] RC_WRITE_MASK = 8'h7b;
   // receive status and enable fields
   localparam int RS_AVAIL = 7;
   localparam int RS_EOF = 6;
   localparam int RS_CRC = 4;
   localparam int RS_FRAME = 3;
   localparam int RS_OVER = 2;
   localparam int RS_ABORT = 1;
   localparam logic [7:0] RECEIVE_IRQ_ENABLE_MASK = 8'hde;
   // transmit status fields
   localparam int TS_AVAIL = 7;
   localparam int TS_DONE = 6;
   localparam int TS_STARVED = 2;
   // reset values
   localparam logic [7:0] RST_RX_CONTROL = 8'h01;
   localparam logic [7:0] RST_RX_VECTOR = 8'h0f;
   localparam logic [7:0] RST_RX_IRQ_EN = 8'h00;
   // mark idle bits that close an aborted frame
   localparam logic [3:0] MARK_IDLE_BITS = 4'h8;
   localparam int RX_DEPTH_BYTES = 8;

   typedef enum logic [2:0] {MODE_ASYNC, MODE_ISOC, MODE_BOP, MODE_BSC, MODE_COP} proto_mode_t;
   typedef enum logic {ABT_IDLE, ABT_FLUSH} abort_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic is_status;
      logic eof;
      logic crc_err;
      logic frame_err;
   } rx_entry_t;

   typedef struct packed {
      rx_entry_t entry;
      logic is_sync;
   } rx_push_t;

   typedef struct packed {
      logic sel;
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } bus_req_t;
endpackage : serial_ctrl_pkg

// File: verilog/serial_rx_tx_ctrl_status_regs.sv
`timescale 1ns/1ps
// byte store with single or double pop, depth a power of two
module rx_byte_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   input wire logic pop_two,
   output logic [W-1:0] out_data,
   output logic [W-1:0] out_next,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;
   logic [CW-1:0] npop;

   // a double pop needs two entries, so a half word is never torn
   assign in_ready = level != CW'(DEPTH);
   assign out_valid = pop_two ? (level >= CW'(2)) : (level != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign npop = pop ? (pop_two ? CW'(2) : CW'(1)) : '0;
   assign out_data = mem[rd_ptr];
   assign out_next = mem[rd_ptr + AW'(1)];

   // storage needs no reset, pointers guard it
   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         rd_ptr <= rd_ptr + npop[AW-1:0];
         level <= level + CW'(push) - npop;
      end
   end
endmodule : rx_byte_fifo

// receive control, data port and status plus transmit status of the serial controller
module serial_rx_tx_ctrl_status_regs
   import serial_ctrl_pkg::*;
#(
   parameter int RX_DEPTH = RX_DEPTH_BYTES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // host register port
   input bus_req_t bus_req,
   input wire logic interrupt_acknowledge_in_n,
   output logic [15:0] bus_rdata,
   output logic irq_n,
   // protocol setup held elsewhere
   input proto_mode_t proto_mode,
   input wire logic word_byte_select,
   input wire logic [7:0] transmit_irq_enable,
   input wire logic [7:0] tx_vector_value,
   input wire logic transmitter_reset_cmd,
   input wire logic transmit_abort_cmd,
   // receive framer
   input rx_push_t rx_push,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic rx_abort_break_evt,
   input wire logic rx_frame_start,
   input wire logic receive_sync_detected,
   output logic rx_hunt,
   // transmit framer
   input wire logic transmit_serial_clock,
   input wire logic tx_fifo_full,
   input wire logic tx_fifo_empty,
   input wire logic tx_closing_bit,
   input wire logic tx_underrun_bit,
   output logic tx_fill_abort,
   output logic tx_fill_sync,
   // dma completion pin
   output logic dma_done_out,
   output logic dma_done_oe,
   // modem ready pin
   input wire logic dsr_in,
   output logic dsr_out,
   output logic dsr_oe,
   output logic modem_dsr_level
);
   localparam int CW = $clog2(RX_DEPTH+1);
   logic [7:0] receive_control;
   logic [7:0] receive_vector;
   logic [7:0] receive_irq_enable;
   logic [6:1] rx_flags;
   logic eof_flag, crc_flag, frame_flag, over_flag, abort_flag;
   logic frame_done, starved, fill_active;
   logic [2:0] txc_pipe;
   logic [1:0] dsr_pipe;
   abort_state_t abort_state;
   logic [3:0] mark_bits;
   logic rx_reset, drop_sync, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_pop;
   logic overrun_evt, crc_push, abort_evt;
   rx_entry_t head, head_next;
   logic [CW-1:0] fifo_level;
   logic receive_data_available;
   logic [7:0] receive_status, transmit_status;
   logic rx_irq, tx_irq, acking;
   logic wr_hit_status, wr_hit_tx_status;
   logic txc_fall, txc_rise, done_set, starve_set;

   assign rx_reset = receive_control[RC_RESET];
   assign acking = !interrupt_acknowledge_in_n;
   assign wr_hit_status = bus_req.sel && bus_req.wr && bus_req.addr == OFF_RX_STATUS;
   assign wr_hit_tx_status = bus_req.sel && bus_req.wr && bus_req.addr == OFF_TX_STATUS;

   // receive control register, reset bit survives its own command
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         receive_control <= RST_RX_CONTROL; // [R24] [R5]
      end
      else if (bus_req.sel && bus_req.wr && bus_req.addr == OFF_RX_CONTROL)
      begin
         receive_control <= bus_req.wdata[7:0] & RC_WRITE_MASK; // [R5]
      end
   end

   // vector and enable registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         receive_vector <= RST_RX_VECTOR; // [R10]
         receive_irq_enable <= RST_RX_IRQ_EN; // [R11]
      end
      else if (bus_req.sel && bus_req.wr)
      begin
         if (bus_req.addr == OFF_RX_VECTOR)
         begin
            receive_vector <= bus_req.wdata[7:0];
         end
         if (bus_req.addr == OFF_RX_IRQ_EN)
         begin
            receive_irq_enable <= bus_req.wdata[7:0] & RECEIVE_IRQ_ENABLE_MASK; // [R11]
         end
      end
   end

   // receive intake: sync stripping and frame discard happen before the fifo
   assign drop_sync = proto_mode == MODE_COP && receive_control[RC_STRIP] && rx_push.is_sync; // [R3]
   assign fifo_in_valid = rx_valid && !drop_sync && !rx_reset && !rx_hunt;
   assign rx_ready = fifo_in_ready || drop_sync || rx_hunt;
   assign overrun_evt = fifo_in_valid && !fifo_in_ready;
   assign crc_push = fifo_in_valid && fifo_in_ready && rx_push.entry.crc_err;
   assign abort_evt = proto_mode == MODE_BOP && receive_control[RC_ABORT_EN] && (overrun_evt || crc_push); // [R4]

   rx_byte_fifo #(
      .W($bits(rx_entry_t)),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .flush(rx_reset), // [R5]
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(rx_push.entry), // [R6]
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .pop_two(word_byte_select),
      .out_data(head),
      .out_next(head_next),
      .level(fifo_level)
   );

   // data port reads pop one byte, or two in word mode
   assign fifo_pop = bus_req.sel && bus_req.rd && bus_req.addr == OFF_RX_DATA && !acking; // [R7]
   assign receive_data_available = fifo_out_valid; // [R8] [R23]

   // discard the rest of a bad frame until the framer sees the next opening
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_hunt <= 1'b0;
      end
      else if (rx_reset || rx_frame_start)
      begin
         rx_hunt <= 1'b0;
      end
      else if (abort_evt)
      begin
         rx_hunt <= 1'b1; // [R4]
      end
   end

   // sticky receive flags; a set wins over a write-one clear in the same cycle, receiver reset wins over both
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_flags <= '0;
      end
      else if (rx_reset)
      begin
         rx_flags <= '0; // [R5]
      end
      else
      begin
         rx_flags[RS_EOF] <= (rx_flags[RS_EOF] && !(wr_hit_status && bus_req.wdata[RS_EOF]))
            || (receive_data_available && head.is_status && head.eof) || abort_evt; // [R4]
         rx_flags[RS_CRC] <= (rx_flags[RS_CRC] && !(wr_hit_status && bus_req.wdata[RS_CRC]))
            || (receive_data_available && head.crc_err);
         rx_flags[RS_FRAME] <= (rx_flags[RS_FRAME] && !(wr_hit_status && bus_req.wdata[RS_FRAME]))
            || (receive_data_available && head.frame_err);
         rx_flags[RS_OVER] <= (rx_flags[RS_OVER] && !(wr_hit_status && bus_req.wdata[RS_OVER])) || overrun_evt;
         rx_flags[RS_ABORT] <= (rx_flags[RS_ABORT] && !(wr_hit_status && bus_req.wdata[RS_ABORT]))
            || rx_abort_break_evt;
         rx_flags[5] <= 1'b0;
      end
   end

   assign eof_flag = rx_flags[RS_EOF];
   assign crc_flag = rx_flags[RS_CRC];
   assign frame_flag = rx_flags[RS_FRAME];
   assign over_flag = rx_flags[RS_OVER];
   assign abort_flag = rx_flags[RS_ABORT];
   assign receive_status = {receive_data_available, eof_flag, 1'b0, crc_flag, frame_flag, over_flag, abort_flag, 1'b0};

   // pins: completion only in dma mode, modem pin direction by select
   assign dma_done_oe = receive_control[RC_DONE_EN] && receive_control[RC_DMA]; // [R1] [R24]
   assign dma_done_out = dma_done_oe && eof_flag; // [R1]
   assign dsr_oe = receive_control[RC_SYNC_PIN]; // [R2]
   assign dsr_out = receive_sync_detected; // [R2]

   // two-stage synchroniser for the modem pin, three-stage pipe for the serial clock
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         dsr_pipe <= '0;
         txc_pipe <= '0;
      end
      else
      begin
         dsr_pipe <= {dsr_pipe[0], dsr_in};
         txc_pipe <= {txc_pipe[1:0], transmit_serial_clock};
      end
   end

   // edges seen two to three system clocks late; fine at a 320 ns serial period
   assign modem_dsr_level = dsr_pipe[1] && !dsr_oe;
   assign txc_fall = txc_pipe[2] && !txc_pipe[1];
   assign txc_rise = !txc_pipe[2] && txc_pipe[1];

   // abort sequencing: frame completion held back until the fifo has drained
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         abort_state <= ABT_IDLE;
         mark_bits <= '0;
      end
      else if (transmitter_reset_cmd)
      begin
         abort_state <= ABT_IDLE;
         mark_bits <= '0;
      end
      else
      begin
         case (abort_state)
            ABT_IDLE:
            begin
               mark_bits <= '0;
               if (transmit_abort_cmd && proto_mode == MODE_BOP)
               begin
                  abort_state <= ABT_FLUSH; // [R16]
               end
            end
            ABT_FLUSH:
            begin
               if (done_set)
               begin
                  abort_state <= ABT_IDLE;
               end
               else if (txc_fall && tx_fifo_empty)
               begin
                  mark_bits <= mark_bits + 4'h1; // [R16]
               end
            end
            default:
            begin
               abort_state <= ABT_IDLE;
            end
         endcase
      end
   end

   // frame completion on the falling serial edge of the closing bit
   always_comb
   begin
      done_set = 1'b0;
      if (proto_mode == MODE_BOP || proto_mode == MODE_BSC || proto_mode == MODE_COP)
      begin
         if (abort_state == ABT_FLUSH)
         begin
            done_set = txc_fall && tx_fifo_empty && (tx_closing_bit || mark_bits == MARK_IDLE_BITS - 4'h1); // [R16]
         end
         else
         begin
            done_set = txc_fall && tx_closing_bit; // [R15] [R17]
         end
      end
   end

   // underrun caught at the rising edge of the eighth bit before the fill
   assign starve_set = txc_rise && tx_underrun_bit && proto_mode != MODE_ASYNC && proto_mode != MODE_ISOC; // [R21]

   // transmit status flags, cleared by writing ones; set wins over clear
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         frame_done <= 1'b0;
         starved <= 1'b0;
      end
      else if (transmitter_reset_cmd)
      begin
         frame_done <= 1'b0; // [R12]
         starved <= 1'b0; // [R12]
      end
      else
      begin
         frame_done <= (frame_done && !(wr_hit_tx_status && bus_req.wdata[TS_DONE])) || done_set; // [R12] [R15]
         starved <= (starved && !(wr_hit_tx_status && bus_req.wdata[TS_STARVED])) || starve_set; // [R12] [R21]
      end
   end

   // fill request to the transmitter until new data shows up
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         fill_active <= 1'b0;
      end
      else if (transmitter_reset_cmd || !tx_fifo_empty)
      begin
         fill_active <= 1'b0; // [R20]
      end
      else if (starve_set)
      begin
         fill_active <= 1'b1; // [R19] [R20]
      end
   end

   assign tx_fill_abort = fill_active && proto_mode == MODE_BOP; // [R19]
   assign tx_fill_sync = fill_active && proto_mode != MODE_BOP; // [R20]
   // availability follows the fifo alone, never the serial clock
   assign transmit_status = {!tx_fifo_full, frame_done, 3'b000, starved, 2'b00}; // [R14]

   // one shared request line, receive served first on acknowledge
   assign rx_irq = |(receive_status & receive_irq_enable); // [R9]
   assign tx_irq = |(transmit_status & transmit_irq_enable); // [R13]
   assign irq_n = !(rx_irq || tx_irq); // [R25]

   // registered read data; unmapped offsets return zero
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         bus_rdata <= 16'h0000;
      end
      else if (acking)
      begin
         bus_rdata <= {8'h00, rx_irq ? receive_vector : tx_vector_value}; // [R10] [R25]
      end
      else if (bus_req.sel && bus_req.rd)
      begin
         case (bus_req.addr)
            OFF_RX_STATUS: bus_rdata <= {8'h00, receive_status};
            OFF_RX_CONTROL: bus_rdata <= {8'h00, receive_control};
            OFF_RX_DATA: bus_rdata <= word_byte_select ? {head.data, head_next.data} : {8'h00, head.data}; // [R7]
            OFF_RX_VECTOR: bus_rdata <= {8'h00, receive_vector};
            OFF_RX_IRQ_EN: bus_rdata <= {8'h00, receive_irq_enable};
            OFF_TX_STATUS: bus_rdata <= {8'h00, transmit_status};
            default: bus_rdata <= 16'h0000;
         endcase
      end
   end

   // checks
   AST_DONE_GATED: assert property (@(posedge clk_sys) disable iff (!nrst) // [R1]
      dma_done_out |-> receive_control[RC_DMA] && receive_control[RC_DONE_EN] && eof_flag)
      else $error("completion driven outside dma mode");
   AST_SYNC_PIN: assert property (@(posedge clk_sys) disable iff (!nrst) // [R2]
      !receive_control[RC_SYNC_PIN] |-> !dsr_oe && modem_dsr_level == dsr_pipe[1])
      else $error("modem pin driven while selected as input");
   AST_STRIP: assert property (@(posedge clk_sys) disable iff (!nrst) // [R3]
      rx_valid && drop_sync && !fifo_pop |=> fifo_level == $past(fifo_level))
      else $error("stripped sync character stored");
   AST_ABORT: assert property (@(posedge clk_sys) disable iff (!nrst) // [R4]
      abort_evt && !rx_reset |=> rx_hunt && eof_flag)
      else $error("bad frame not discarded");
   AST_RESET_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst) // [R5]
      rx_reset |=> fifo_level == '0 && rx_flags == '0
         && (receive_control[RC_RESET] || $past(bus_req.sel && bus_req.wr && bus_req.addr == OFF_RX_CONTROL)))
      else $error("receiver reset left state behind");
   AST_DEPTH: assert property (@(posedge clk_sys) disable iff (!nrst) // [R6]
      fifo_level <= CW'(RX_DEPTH))
      else $error("receive store above its depth");
   AST_POP_BYTE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R7]
      fifo_pop && receive_data_available && !word_byte_select && !fifo_in_valid && !rx_reset |=> fifo_level == $past(fifo_level) - CW'(1))
      else $error("byte read did not pop one entry");
   AST_RDA_READ: assert property (@(posedge clk_sys) disable iff (!nrst) // [R8]
      bus_req.sel && bus_req.rd && bus_req.addr == OFF_RX_STATUS && !acking |=> bus_rdata[RS_AVAIL] == $past(receive_data_available))
      else $error("data-available misreported");
   AST_IRQ: assert property (@(posedge clk_sys) disable iff (!nrst) // [R9]
      (receive_status & receive_irq_enable) != 8'h00 |-> !irq_n)
      else $error("enabled receive condition without request");
   AST_VECTOR: assert property (@(posedge clk_sys) disable iff (!nrst) // [R10]
      acking && rx_irq |=> bus_rdata == {8'h00, $past(receive_vector)})
      else $error("receive vector not presented");
   AST_TX_AVAIL: assert property (@(posedge clk_sys) disable iff (!nrst) // [R14]
      transmit_status[TS_AVAIL] != tx_fifo_full)
      else $error("transmit-available wrong");
   AST_FRAME_DONE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R15]
      done_set && !transmitter_reset_cmd |=> frame_done ##1 (frame_done || $past(wr_hit_tx_status)))
      else $error("frame-complete not held");
   AST_STARVE: assert property (@(posedge clk_sys) disable iff (!nrst) // [R21]
      starve_set && !transmitter_reset_cmd |=> starved && (fill_active || !tx_fifo_empty))
      else $error("underrun not recorded");
   COV_WORD_READ: cover property (@(posedge clk_sys) disable iff (!nrst) fifo_pop && receive_data_available && word_byte_select);
   COV_ABORT_FLUSH: cover property (@(posedge clk_sys) disable iff (!nrst) abort_state == ABT_FLUSH && done_set);
   COV_OVERRUN: cover property (@(posedge clk_sys) disable iff (!nrst) overrun_evt);
endmodule : serial_rx_tx_ctrl_status_regs

// File: testbench/framer_model.sv
`timescale 1ns/1ps
// framer stand-in: pushes received bytes and makes serial clock bursts
module framer_model
   import serial_ctrl_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // receive push side
   output rx_push_t rx_push,
   output logic rx_valid,
   input wire logic rx_ready,
   // serial clock pin, still between bursts
   output logic transmit_serial_clock
);
   // idle values at time zero
   initial
   begin
      rx_push = '0;
      rx_valid = 1'b0;
      transmit_serial_clock = 1'b0;
   end
   // data is inverted after release so a stale byte never passes for new
   task push(input logic [7:0] d, input logic s);
      @(negedge clk_sys);
      while (rx_ready !== 1'b1)
         @(negedge clk_sys);
      rx_push.entry.data = d;
      rx_push.is_sync = s;
      rx_valid = 1'b1;
      @(negedge clk_sys);
      rx_valid = 1'b0;
      rx_push.entry.data = ~d;
   endtask : push
   // 320 ns serial periods, offset so edges never line up with clk_sys
   task burst(input int n);
      #7;
      repeat (n)
      begin
         #160 transmit_serial_clock = 1'b1;
         #160 transmit_serial_clock = 1'b0;
      end
   endtask : burst
endmodule : framer_model

// File: testbench/test_serial_rx_tx_ctrl_status_regs.sv
`timescale 1ns/1ps
// register-level bench, inputs change at the falling edge except the serial clock
module test_serial_rx_tx_ctrl_status_regs;
   import serial_ctrl_pkg::*;
   logic clk_sys = 1'b0, nrst = 1'b0, interrupt_acknowledge_in_n = 1'b1, word_byte_select = 1'b0;
   bus_req_t bus_req = '0;
   proto_mode_t proto_mode = MODE_BOP;
   logic [7:0] transmit_irq_enable = 8'h00, tx_vector_value = 8'h3c;
   logic transmitter_reset_cmd = 1'b0, transmit_abort_cmd = 1'b0, tx_fifo_full = 1'b0, tx_fifo_empty = 1'b0;
   logic tx_closing_bit = 1'b0, tx_underrun_bit = 1'b0, rx_abort_break_evt = 1'b0, rx_frame_start = 1'b0;
   logic receive_sync_detected = 1'b1, dsr_in = 1'b1;
   rx_push_t rx_push;
   logic rx_valid, rx_ready, transmit_serial_clock, irq_n, rx_hunt, tx_fill_abort, tx_fill_sync;
   logic dma_done_out, dma_done_oe, dsr_out, dsr_oe, modem_dsr_level;
   logic [15:0] bus_rdata;
   int failures = 0, tests_run = 0;
   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;
   serial_rx_tx_ctrl_status_regs serial_rx_tx_ctrl_status_regs_inst (.clk_sys, .nrst, .bus_req,
      .interrupt_acknowledge_in_n, .bus_rdata, .irq_n, .proto_mode, .word_byte_select, .transmit_irq_enable,
      .tx_vector_value, .transmitter_reset_cmd, .transmit_abort_cmd, .rx_push, .rx_valid, .rx_ready,
      .rx_abort_break_evt, .rx_frame_start, .receive_sync_detected, .rx_hunt, .transmit_serial_clock,
      .tx_fifo_full, .tx_fifo_empty, .tx_closing_bit, .tx_underrun_bit, .tx_fill_abort, .tx_fill_sync,
      .dma_done_out, .dma_done_oe, .dsr_in, .dsr_out, .dsr_oe, .modem_dsr_level);
   framer_model framer_model_inst (.clk_sys, .rx_push, .rx_valid, .rx_ready, .transmit_serial_clock);
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      bus_req = '{1'b1, 1'b0, 1'b1, a, d};
      @(negedge clk_sys);
      bus_req = '0;
   endtask : wr
   // read then compare; data stands from the cycle after the taking edge
   task rdc(input string n, input logic [4:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      bus_req = '{1'b1, 1'b1, 1'b0, a, 16'h0000};
      @(negedge clk_sys);
      bus_req = '0;
      chk(n, e, bus_rdata);
   endtask : rdc
   task test_done;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      failures++;
      test_done();
   end
   // main sequence
   initial
   begin
      repeat (2) @(negedge clk_sys);
      nrst = 1'b1;
      rdc("rvec", OFF_RX_VECTOR, 16'h000f);
      rdc("rien", OFF_RX_IRQ_EN, 16'h0000);
      rdc("rctl", OFF_RX_CONTROL, 16'h0001);
      rdc("tsr", OFF_TX_STATUS, 16'h0080);
      framer_model_inst.push(8'h11, 1'b0);
      rdc("rsr", OFF_RX_STATUS, 16'h0000);
      wr(OFF_RX_CONTROL, 16'h0000);
      for (int i = 0; i < 8; i++)
         framer_model_inst.push(8'ha0 + i[7:0], 1'b0);
      @(negedge clk_sys);
      chk("full", 16'h0000, {15'h0000, rx_ready});
      for (int i = 0; i < 8; i++)
      begin
         rdc("rsr", OFF_RX_STATUS, 16'h0080);
         rdc("rdat", OFF_RX_DATA, 16'h00a0 + i[15:0]);
      end
      rdc("rsr", OFF_RX_STATUS, 16'h0000);
      framer_model_inst.push(8'h22, 1'b0);
      wr(OFF_RX_CONTROL, 16'h0001);
      rdc("rsr", OFF_RX_STATUS, 16'h0000);
      rdc("rctl", OFF_RX_CONTROL, 16'h0001);
      // sync stripping in character mode
      proto_mode = MODE_COP;
      wr(OFF_RX_CONTROL, 16'h0008);
      framer_model_inst.push(8'h32, 1'b1);
      framer_model_inst.push(8'h5a, 1'b0);
      rdc("rdat", OFF_RX_DATA, 16'h005a);
      rdc("rsr", OFF_RX_STATUS, 16'h0000);
      // receive interrupt, vector on acknowledge
      wr(OFF_RX_IRQ_EN, 16'h00ff);
      rdc("rien", OFF_RX_IRQ_EN, 16'h00de);
      chk("irq", 16'h0001, {15'h0000, irq_n});
      rx_abort_break_evt = 1'b1;
      @(negedge clk_sys);
      rx_abort_break_evt = 1'b0;
      @(negedge clk_sys);
      chk("irq", 16'h0000, {15'h0000, irq_n});
      rdc("rsr", OFF_RX_STATUS, 16'h0002);
      wr(OFF_RX_VECTOR, 16'h0055);
      interrupt_acknowledge_in_n = 1'b0;
      @(negedge clk_sys);
      interrupt_acknowledge_in_n = 1'b1;
      chk("ivec", 16'h0055, bus_rdata);
      wr(OFF_RX_STATUS, 16'h0002);
      chk("irq", 16'h0001, {15'h0000, irq_n});
      // modem pin and completion pin
      wr(OFF_RX_CONTROL, 16'h0010);
      chk("dsr", 16'h0003, {14'h0000, dsr_oe, dsr_out});
      wr(OFF_RX_CONTROL, 16'h0020);
      dsr_in = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("dsrin", 16'h0000, {14'h0000, dsr_oe, modem_dsr_level});
      chk("doe", 16'h0000, {15'h0000, dma_done_oe});
      wr(OFF_RX_CONTROL, 16'h0060);
      chk("doe", 16'h0001, {15'h0000, dma_done_oe});
      // transmit status from serial clock edges
      proto_mode = MODE_BOP;
      transmit_irq_enable = 8'h44;
      tx_closing_bit = 1'b1;
      tx_underrun_bit = 1'b1;
      framer_model_inst.burst(1);
      repeat (4) @(negedge clk_sys);
      tx_closing_bit = 1'b0;
      tx_underrun_bit = 1'b0;
      repeat (5) @(negedge clk_sys);
      rdc("tsr", OFF_TX_STATUS, 16'h00c4);
      chk("irq", 16'h0000, {15'h0000, irq_n});
      framer_model_inst.burst(1);
      wr(OFF_TX_STATUS, 16'h0044);
      rdc("tsr", OFF_TX_STATUS, 16'h0080);
      chk("irq", 16'h0001, {15'h0000, irq_n});
      tx_fifo_full = 1'b1;
      tx_closing_bit = 1'b1;
      framer_model_inst.burst(1);
      repeat (4) @(negedge clk_sys);
      tx_closing_bit = 1'b0;
      repeat (5) @(negedge clk_sys);
      rdc("tsr", OFF_TX_STATUS, 16'h0040);
      tx_fifo_full = 1'b0;
      transmitter_reset_cmd = 1'b1;
      @(negedge clk_sys);
      transmitter_reset_cmd = 1'b0;
      rdc("tsr", OFF_TX_STATUS, 16'h0080);
      // abort: completion only after eight mark bits with the fifo empty
      tx_fifo_empty = 1'b1;
      transmit_abort_cmd = 1'b1;
      @(negedge clk_sys);
      transmit_abort_cmd = 1'b0;
      framer_model_inst.burst(7);
      repeat (5) @(negedge clk_sys);
      rdc("tsr", OFF_TX_STATUS, 16'h0080);
      framer_model_inst.burst(1);
      repeat (5) @(negedge clk_sys);
      rdc("tsr", OFF_TX_STATUS, 16'h00c0);
      test_done();
   end
endmodule : test_serial_rx_tx_ctrl_status_regs
